/* core/fcl_pkg.sv */
// package: constants for the frequency-control voltage and current-limit block
package fcl_pkg;

    // ------------------------------------------------------------
    // attribute offsets (decimal 3022..3025)
    // ------------------------------------------------------------
    localparam logic [11:0] ATTR_GUARD_ENABLE = 12'h0BCE; // one byte, 0 off / 1 on
    localparam logic [11:0] ATTR_DERIV_GAIN = 12'h0BCF; // seconds
    localparam logic [11:0] ATTR_INTEG_GAIN = 12'h0BD0; // counts per amp-second
    localparam logic [11:0] ATTR_PROP_GAIN = 12'h0BD1; // counts per amp

    // ------------------------------------------------------------
    // reset values and the enable value
    // ------------------------------------------------------------
    localparam logic [7:0] GUARD_ENABLE_RST = 8'h00; // limiter off after power-up
    localparam logic [7:0] GUARD_ON_VALUE = 8'h01; // the only value that enables
    localparam logic [31:0] DERIV_GAIN_RST = 32'h0000_0000; // plain default
    localparam logic [31:0] INTEG_GAIN_RST = 32'h0000_1000; // plain default, q16.16
    localparam logic [31:0] PROP_GAIN_RST = 32'h0001_0000; // plain default, 1.0 in q16.16
    localparam logic [15:0] USER_CAP_RST = 16'h03E8; // 100.0 % in tenths

    // ------------------------------------------------------------
    // field layout and scaling
    // ------------------------------------------------------------
    localparam int Q_FRAC = 16; // fraction bits of all gains and ratios
    localparam logic [15:0] PCT_TENTHS_FULL = 16'h03E8; // 100.0 % expressed in tenths
    localparam logic [16:0] RATIO_MAX = 17'h1_0000; // unity ratio in q16

    // ------------------------------------------------------------
    // control modes and pipeline timing
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_BASIC_VHZ,   // plain curve, points computed elsewhere
        MODE_FAN_PUMP,    // square-law curve
        MODE_SENSORLESS,  // curve plus slip and dynamic boost
        MODE_NOT_FREQ     // position or velocity loop, not frequency control
    } fcl_mode_e;

    localparam int FANPUMP_LATENCY = 3; // clock edges from input to curve voltage

endpackage : fcl_pkg

/* core/fcl_fanpump.sv */
// module: square-law fan/pump voltage curve, three-stage pipeline
`timescale 1ns/1ns
`default_nettype none

module fcl_fanpump
    import fcl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic [15:0] freqAbs, // magnitude of output frequency
    input wire logic [15:0] ratedFreq, // motor rated frequency
    input wire logic [15:0] ratedVolt, // motor rated voltage
    input wire logic [15:0] runBoostVolt, // run-boost voltage
    output logic [15:0] curveVolt // resulting output voltage
);

    // ------------------------------------------------------------
    // pipeline registers
    // ------------------------------------------------------------
    logic [16:0] ratio_q, ratio_d; // f / fn in q16, clamped to unity
    logic [16:0] square_q, square_d; // ratio squared in q16
    logic [15:0] volt_q, volt_d; // final voltage
    logic [15:0] boostS1_q, boostS2_q; // run boost delayed alongside
    logic [15:0] spanS1_d, spanS1_q, spanS2_q; // rated minus boost, delayed

    // ------------------------------------------------------------
    // next-value logic
    // ------------------------------------------------------------
    // only run boost enters here; break points and start boost do not
    always_comb
    begin
        logic [31:0] quot;
        logic [33:0] sq;
        logic [32:0] scaled;
        quot = 32'h0000_0000;
        sq = '0;
        scaled = '0;
        // zero rated frequency is a setup error; clamp rather than divide by zero
        if (ratedFreq == 16'h0000)
            ratio_d = RATIO_MAX;
        else
        begin
            quot = {freqAbs, 16'h0000} / {16'h0000, ratedFreq};
            ratio_d = (quot > {15'h0000, RATIO_MAX}) ? RATIO_MAX : quot[16:0];
        end
        // a boost above rated voltage would wrap; floor the span at zero
        spanS1_d = (ratedVolt > runBoostVolt) ? ratedVolt - runBoostVolt : 16'h0000;
        sq = ratio_q * ratio_q;
        square_d = sq[32:16];
        // v = (f/fn)^2 * (vn - vboost) + vboost
        scaled = square_q * spanS2_q;
        volt_d = scaled[31:16] + boostS2_q;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ratio_q <= '0;
            square_q <= '0;
            volt_q <= '0;
            boostS1_q <= '0;
            boostS2_q <= '0;
            spanS1_q <= '0;
            spanS2_q <= '0;
        end
        else
        begin
            ratio_q <= ratio_d;
            square_q <= square_d;
            volt_q <= volt_d;
            boostS1_q <= runBoostVolt;
            boostS2_q <= boostS1_q;
            spanS1_q <= spanS1_d;
            spanS2_q <= spanS1_q;
        end
    end

    assign curveVolt = volt_q;

endmodule : fcl_fanpump

`default_nettype wire

/* core/fcl_drive_ctrl.sv */
// module: frequency-control voltage shaping and current limiter with attribute port
// Function
// - fan/pump voltage follows square-law frequency curve
// - fan/pump uses run boost only
// - sensorless mode estimates slip from volts, amps
// - sensorless mode adds dynamic resistive voltage boost
// - limiter holds output current below ceiling
// - ceiling is minimum of five limits
// - PI(D) regulator reshapes the velocity reference
// - enable attribute byte, 0 off, 1 on
// - limiter acts only in frequency control, running
// - derivative gain attribute, in seconds
// - integral gain attribute, counts per amp-second
// - proportional gain attribute, counts per amp
// - user cap lowers ceiling, defaults 100 percent
`timescale 1ns/1ns
`default_nettype none

module fcl_drive_ctrl
    import fcl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    // attribute access
    input wire logic attrReq,
    input wire logic attrWrite,
    input wire logic [11:0] attrId,
    input wire logic [31:0] attrWrData,
    output logic attrAck,
    output logic attrErr,
    output logic [31:0] attrRdData,
    // configuration and command
    input wire fcl_mode_e ctrlMode,
    input wire logic motion_drive_start_cmd,
    input wire logic sampleTick,
    input wire logic [15:0] user_current_cap,
    input wire logic [15:0] ratedCurrent,
    input wire logic [15:0] motorThermalLimit,
    input wire logic [15:0] inverterThermalLimit,
    input wire logic [15:0] motorPeakLimit,
    input wire logic [15:0] drivePeakLimit,
    // motor model
    input wire logic [15:0] ratedFreq,
    input wire logic [15:0] ratedVolt,
    input wire logic [15:0] ratedSlip,
    input wire logic [15:0] statorRes,
    input wire logic [15:0] runBoostVolt,
    input wire logic [15:0] basicCurveVolt,
    // loop signals
    input wire logic signed [15:0] velocityReference,
    input wire logic [15:0] output_current_value,
    input wire logic [15:0] appliedVolt,
    output logic signed [15:0] freqCommand,
    output logic [15:0] outputVoltage,
    output logic [15:0] slipEstimate,
    output logic [15:0] effective_current_ceiling,
    output logic limiterActive
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // smaller of two unsigned limits
    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction : min16

    // signed q16.16 gain times signed error, result truncated to 32 bits
    function automatic logic signed [31:0] gainMul(input logic signed [31:0] g,
                                                   input logic signed [17:0] e);
        logic signed [49:0] p;
        p = g * e;
        gainMul = p[Q_FRAC +: 32];
    endfunction : gainMul

    // ------------------------------------------------------------
    // attribute store
    // ------------------------------------------------------------
    logic [7:0] guardEnable_q, guardEnable_d; // overcurrent_guard_enable
    logic [31:0] derivGain_q, derivGain_d; // limiter_derivative_gain
    logic [31:0] integGain_q, integGain_d; // limiter_integral_gain
    logic [31:0] propGain_q, propGain_d; // limiter_proportional_gain
    logic ack_q, ack_d;
    logic err_q, err_d;
    logic [31:0] rd_q, rd_d;
    // decode one request per cycle; answer on the next edge
    always_comb
    begin
        logic wr; // a write request this cycle
        wr = attrReq && attrWrite;
        guardEnable_d = guardEnable_q;
        derivGain_d = (wr && attrId == ATTR_DERIV_GAIN) ? attrWrData : derivGain_q;
        integGain_d = (wr && attrId == ATTR_INTEG_GAIN) ? attrWrData : integGain_q;
        propGain_d = (wr && attrId == ATTR_PROP_GAIN) ? attrWrData : propGain_q;
        ack_d = attrReq;
        err_d = 1'b0;
        rd_d = rd_q;
        if (attrReq)
        begin
            case (attrId)
                ATTR_GUARD_ENABLE:
                begin
                    rd_d = {24'h00_0000, guardEnable_q};
                    // only 0 or 1 is a legal byte; anything else is refused
                    if (attrWrite && (attrWrData[31:1] == 31'h0000_0000))
                        guardEnable_d = attrWrData[7:0];
                    else if (attrWrite)
                        err_d = 1'b1;
                end
                ATTR_DERIV_GAIN:
                    rd_d = derivGain_q; // old value even on a write
                ATTR_INTEG_GAIN:
                    rd_d = integGain_q;
                ATTR_PROP_GAIN:
                    rd_d = propGain_q;
                default:
                begin
                    // unknown attribute: refused, reads zero
                    err_d = 1'b1;
                    rd_d = 32'h0000_0000;
                end
            endcase
        end
    end
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            guardEnable_q <= GUARD_ENABLE_RST; // limiter off after power-up
            derivGain_q <= DERIV_GAIN_RST;
            integGain_q <= INTEG_GAIN_RST;
            propGain_q <= PROP_GAIN_RST;
            ack_q <= 1'b0;
            err_q <= 1'b0;
            rd_q <= 32'h0000_0000;
        end
        else
        begin
            guardEnable_q <= guardEnable_d;
            derivGain_q <= derivGain_d;
            integGain_q <= integGain_d;
            propGain_q <= propGain_d;
            ack_q <= ack_d;
            err_q <= err_d;
            rd_q <= rd_d;
        end
    end

    // ------------------------------------------------------------
    // current ceiling
    // ------------------------------------------------------------
    logic [15:0] userCapAmps; // user cap turned from tenths of percent into amps
    logic [31:0] capProd;
    logic [15:0] ceiling_q, ceiling_d;
    always_comb
    begin
        // cap scales rated current, so it can sit below both peak limits
        capProd = ratedCurrent * user_current_cap;
        userCapAmps = 16'((capProd / {16'h0000, PCT_TENTHS_FULL}) > 32'h0000_FFFF ?
                      32'h0000_FFFF : capProd / {16'h0000, PCT_TENTHS_FULL});
        // smallest of the five
        ceiling_d = min16(min16(min16(motorThermalLimit, inverterThermalLimit),
                                min16(motorPeakLimit, drivePeakLimit)), userCapAmps);
    end

    // ------------------------------------------------------------
    // current limiter regulator
    // ------------------------------------------------------------
    logic active; // limiter may act this cycle
    logic signed [31:0] integ_q, integ_d; // integral state, never below zero
    logic signed [17:0] prevErr_q, prevErr_d; // last error for the derivative term
    logic signed [15:0] freqCmd_q, freqCmd_d;
    // enable byte, frequency control and a running start command together
    assign active = (guardEnable_q == GUARD_ON_VALUE) && (ctrlMode != MODE_NOT_FREQ)
                    && motion_drive_start_cmd;
    always_comb
    begin
        logic signed [17:0] err;
        logic signed [31:0] adj, refMag, integNext;
        err = $signed({2'b00, output_current_value}) - $signed({2'b00, ceiling_q});
        refMag = velocityReference[15] ? -32'(velocityReference) : 32'(velocityReference);
        integNext = integ_q + gainMul(integGain_q, err);
        integ_d = integ_q;
        prevErr_d = prevErr_q;
        freqCmd_d = freqCmd_q;
        adj = 32'sh0000_0000;
        if (!active)
        begin
            // straight through with regulator cleared
            integ_d = 32'sh0000_0000;
            prevErr_d = 18'sh0_0000;
            freqCmd_d = velocityReference;
        end
        else if (sampleTick)
        begin
            // integral only pulls back; clamping at zero stops windup below the ceiling
            integ_d = (integNext < 0) ? 32'sh0000_0000 :
                      (integNext > refMag) ? refMag : integNext;
            prevErr_d = err;
            // proportional, integral and derivative parts
            adj = gainMul(propGain_q, err) + integ_d + gainMul(derivGain_q, err - prevErr_q);
            // trims reference magnitude only, never reverses it
            if (adj < 0)
                adj = 32'sh0000_0000;
            else if (adj > refMag)
                adj = refMag;
            freqCmd_d = velocityReference[15] ? velocityReference + 16'(adj) :
                                                velocityReference - 16'(adj);
        end
    end
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            ceiling_q <= 16'h0000;
            integ_q <= 32'sh0000_0000;
            prevErr_q <= 18'sh0_0000;
            freqCmd_q <= 16'sh0000;
        end
        else
        begin
            ceiling_q <= ceiling_d;
            integ_q <= integ_d;
            prevErr_q <= prevErr_d;
            freqCmd_q <= freqCmd_d;
        end
    end

    // ------------------------------------------------------------
    // voltage shaping, slip estimate and boost
    // ------------------------------------------------------------
    logic [15:0] fanVolt; // square-law curve from the pipeline
    logic [15:0] freqAbs;
    logic [15:0] slip_q, slip_d;
    logic [15:0] volt_q, volt_d;
    assign freqAbs = freqCmd_q[15] ? 16'(-freqCmd_q) : 16'(freqCmd_q);
    fcl_fanpump uFanPump (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .freqAbs(freqAbs),
        .ratedFreq(ratedFreq),
        .ratedVolt(ratedVolt),
        .runBoostVolt(runBoostVolt),
        .curveVolt(fanVolt)
    );
    always_comb
    begin
        logic [31:0] power, slipProd, irDrop;
        logic [16:0] sum;
        // electrical load proxy from applied volts and measured amps
        power = appliedVolt * output_current_value;
        slipProd = power[31:16] * ratedSlip;
        slip_d = (ctrlMode == MODE_SENSORLESS) ? slipProd[31:16] : 16'h0000;
        // resistive drop compensation; set by current alone, not by speed, and aids starting
        irDrop = output_current_value * statorRes;
        sum = {1'b0, basicCurveVolt} + {1'b0, irDrop[31:16]};
        case (ctrlMode)
            MODE_FAN_PUMP: volt_d = fanVolt;
            MODE_SENSORLESS: volt_d = sum[16] ? 16'hFFFF : sum[15:0];
            MODE_BASIC_VHZ: volt_d = basicCurveVolt;
            default: volt_d = 16'h0000; // not a frequency-control mode
        endcase
    end
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            slip_q <= 16'h0000;
            volt_q <= 16'h0000;
        end
        else
        begin
            slip_q <= slip_d;
            volt_q <= volt_d;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign attrAck = ack_q;
    assign attrErr = err_q;
    assign attrRdData = rd_q;
    assign freqCommand = freqCmd_q;
    assign outputVoltage = volt_q;
    assign slipEstimate = slip_q;
    assign effective_current_ceiling = ceiling_q;
    assign limiterActive = active;

endmodule : fcl_drive_ctrl

`default_nettype wire

/* sim/fcl_drive_ctrl_assertions.sv */
// checker: port-level assertions for the drive control block
`timescale 1ns/1ns
`default_nettype none

module fcl_chk
    import fcl_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic attrReq,
    input wire logic attrWrite,
    input wire logic [11:0] attrId,
    input wire logic [31:0] attrWrData,
    input wire logic attrAck,
    input wire logic attrErr,
    input wire logic [31:0] attrRdData,
    input wire fcl_mode_e ctrlMode,
    input wire logic motion_drive_start_cmd,
    input wire logic sampleTick,
    input wire logic [15:0] motorThermalLimit,
    input wire logic [15:0] inverterThermalLimit,
    input wire logic [15:0] motorPeakLimit,
    input wire logic [15:0] drivePeakLimit,
    input wire logic signed [15:0] velocityReference,
    input wire logic [15:0] output_current_value,
    input wire logic signed [15:0] freqCommand,
    input wire logic [15:0] outputVoltage,
    input wire logic [15:0] slipEstimate,
    input wire logic [15:0] effective_current_ceiling,
    input wire logic limiterActive
);
    // ----------------------------------------------------------------
    // one clock domain, so clocking and reset are stated once
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_ack_next_edge: assert property (attrReq |=> attrAck)
        else $error("attribute answer missing");
    a_quiet_no_req: assert property (!attrReq |=> !attrAck && !attrErr)
        else $error("answer without request");
    a_bad_id_err: assert property (attrReq && (attrId < ATTR_GUARD_ENABLE ||
        attrId > ATTR_PROP_GAIN) |=> attrErr && attrRdData == 32'h0000_0000)
        else $error("unknown attribute not refused");
    a_enable_refused: assert property (attrReq && attrWrite && attrId == ATTR_GUARD_ENABLE
        && attrWrData[7:0] > GUARD_ON_VALUE |=> attrErr)
        else $error("bad enable value accepted");
    a_active_gate: assert property (limiterActive |->
        ctrlMode != MODE_NOT_FREQ && motion_drive_start_cmd)
        else $error("limiter active outside frequency control run");
    a_ceiling_min: assert property (effective_current_ceiling <= $past(motorThermalLimit)
        && effective_current_ceiling <= $past(inverterThermalLimit)
        && effective_current_ceiling <= $past(motorPeakLimit)
        && effective_current_ceiling <= $past(drivePeakLimit))
        else $error("ceiling above a limit");
    a_pass_through: assert property (!limiterActive |=>
        freqCommand == $past(velocityReference))
        else $error("inactive limiter altered reference");
    a_hold_between: assert property (limiterActive && !sampleTick |=> $stable(freqCommand))
        else $error("frequency command moved without tick");
    a_toward_zero: assert property (limiterActive && sampleTick && !velocityReference[15] |=>
        !freqCommand[15] && freqCommand <= $past(velocityReference))
        else $error("limiter pushed command away from zero");
    a_slip_zero: assert property (ctrlMode != MODE_SENSORLESS |=> slipEstimate == 16'h0000)
        else $error("slip estimate outside sensorless mode");
    // covers for the main scenarios
    c_limit_tick: cover property (limiterActive && sampleTick &&
        output_current_value > effective_current_ceiling);
    c_refused: cover property (attrErr);
    c_fan_pump: cover property (ctrlMode == MODE_FAN_PUMP && outputVoltage != 16'h0000);
endmodule : fcl_chk

bind fcl_drive_ctrl fcl_chk u_fcl_chk (.*);

`default_nettype wire

/* sim/fcl_motor_model.sv */
// partner: induction motor seen as a current that follows load and speed
`timescale 1ns/1ns
`default_nettype none

module fcl_motor_model (
    input wire logic clk_sys,
    input wire logic rstn,
    input wire logic signed [15:0] freqCommand,
    input wire logic [15:0] loadAmps, // impact load set by the bench
    output logic [15:0] output_current_value
);
    // a small machine, so no stability control is asked of the controller
    logic [15:0] speedMag; // magnitude of the commanded frequency
    logic [15:0] curr_d;
    logic [15:0] curr_q;
    // ----------------------------------------------------------------
    // current rises with load and speed, one cycle of lag
    // ----------------------------------------------------------------
    always_comb
    begin
        speedMag = freqCommand[15] ? 16'(-freqCommand) : 16'(freqCommand);
        curr_d = loadAmps + (speedMag >> 2);
    end
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            curr_q <= 16'h0000;
        else
            curr_q <= curr_d;
    end
    assign output_current_value = curr_q;
endmodule : fcl_motor_model

`default_nettype wire

/* sim/testbench.sv */
// testbench: attribute table, ceiling, limiter and voltage curves
`timescale 1ns/1ns
`default_nettype none

module testbench
    import fcl_pkg::*;
;
    typedef struct {logic wr; logic [11:0] id; logic [31:0] data; logic err; logic [31:0] rd;} fcl_row_s;
    // ----------------------------------------------------------------
    // stimulus, all given at time zero
    // ----------------------------------------------------------------
    logic clk_sys = 1'b0, rstn = 1'b0, attrReq = 1'b0, attrWrite = 1'b0;
    logic [11:0] attrId = 12'h000;
    logic [31:0] attrWrData = 32'h0000_0000;
    fcl_mode_e ctrlMode = MODE_BASIC_VHZ;
    logic motion_drive_start_cmd = 1'b0, sampleTick = 1'b1;
    logic [15:0] user_current_cap = 16'h03E8, ratedCurrent = 16'h00C8;
    logic [15:0] lim [4] = '{16'h012C, 16'h012C, 16'h012C, 16'h012C};
    logic [15:0] ratedFreq = 16'h0064, ratedVolt = 16'h0190, ratedSlip = 16'h8000;
    logic [15:0] statorRes = 16'h8000, runBoostVolt = 16'h0028, basicCurveVolt = 16'h0064;
    logic signed [15:0] velocityReference = 16'sh0000;
    logic [15:0] appliedVolt = 16'h1000, loadAmps = 16'h0000;
    logic attrAck, attrErr, limiterActive;
    logic [31:0] attrRdData;
    logic signed [15:0] freqCommand;
    logic [15:0] output_current_value, outputVoltage, slipEstimate, effective_current_ceiling;
    int numErrors = 0, nCompared = 0;
    // fan/pump cases: reference, expected voltage (boost 40, rated 100 Hz / 400 V)
    logic [15:0] fp [4][2] = '{'{16'h0032, 16'h0082}, '{16'h0064, 16'h0190},
        '{16'h0000, 16'h0028}, '{16'hFFCE, 16'h0082}};
    // accesses: reads of defaults, refusals, write then read back
    fcl_row_s rows [11] = '{
        '{1'b0, ATTR_GUARD_ENABLE, 32'h0000_0000, 1'b0, 32'h0000_0000},
        '{1'b0, ATTR_DERIV_GAIN, 32'h0000_0000, 1'b0, DERIV_GAIN_RST},
        '{1'b0, ATTR_INTEG_GAIN, 32'h0000_0000, 1'b0, INTEG_GAIN_RST},
        '{1'b0, ATTR_PROP_GAIN, 32'h0000_0000, 1'b0, PROP_GAIN_RST},
        '{1'b1, ATTR_GUARD_ENABLE, 32'h0000_0002, 1'b1, 32'h0000_0000},
        '{1'b1, ATTR_GUARD_ENABLE, 32'h0000_0001, 1'b0, 32'h0000_0000},
        '{1'b0, ATTR_GUARD_ENABLE, 32'h0000_0000, 1'b0, 32'h0000_0001},
        '{1'b1, ATTR_DERIV_GAIN, 32'h1234_5678, 1'b0, 32'h0000_0000},
        '{1'b1, ATTR_DERIV_GAIN, 32'h0000_0000, 1'b0, 32'h1234_5678},
        '{1'b0, 12'hBD2, 32'h0000_0000, 1'b1, 32'h0000_0000},
        '{1'b1, 12'hBCD, 32'h0000_0005, 1'b1, 32'h0000_0000}};

    always #4 clk_sys = ~clk_sys;

    fcl_drive_ctrl u_fcl_drive_ctrl (.*, .motorThermalLimit(lim[0]),
        .inverterThermalLimit(lim[1]), .motorPeakLimit(lim[2]), .drivePeakLimit(lim[3]));
    fcl_motor_model u_fcl_motor_model (.*);

    // ----------------------------------------------------------------
    // compare, access and closing tasks
    // ----------------------------------------------------------------
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nCompared++;
        if (got !== exp)
        begin
            numErrors++;
            $display("FAIL %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    // request at a falling edge, answer looked at a cycle later, then one idle edge
    task automatic attr(input fcl_row_s r);
        {attrReq, attrWrite, attrId, attrWrData} = {1'b1, r.wr, r.id, r.data};
        @(negedge clk_sys);
        attrReq = 1'b0;
        check("attrAck", 32'h0000_0001, {31'h0, attrAck});
        check("attrErr", {31'h0, r.err}, {31'h0, attrErr});
        check("attrRdData", r.rd, attrRdData);
        @(negedge clk_sys);
    endtask : attr

    task automatic close_out();
        $display("compared %0d, mismatches %0d", nCompared, numErrors);
        if (numErrors == 0 && nCompared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : close_out

    // a hang is cut short and counted
    initial
    begin
        #400000;
        numErrors++;
        close_out();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        repeat (5) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        foreach (rows[i]) attr(rows[i]);
        check("ceiling cap", 32'h0000_00C8, {16'h0, effective_current_ceiling});
        for (int i = 0; i < 4; i++)
        begin
            lim[i] = 16'h0096;
            repeat (2) @(negedge clk_sys);
            check("ceiling min", 32'h0000_0096, {16'h0, effective_current_ceiling});
            lim[i] = 16'h012C;
        end
        user_current_cap = 16'h01F4; // 50 % of 200 A lowers it below the peaks
        repeat (2) @(negedge clk_sys);
        check("ceiling cap", 32'h0000_0064, {16'h0, effective_current_ceiling});
        user_current_cap = 16'h03E8;
        // heavy impact load while running: the command is pulled in
        {velocityReference, loadAmps, motion_drive_start_cmd} = {16'sh03E8, 16'h0190, 1'b1};
        repeat (10) @(negedge clk_sys);
        sampleTick = 1'b0; // a gap in the ticks must freeze the command
        repeat (3) @(negedge clk_sys);
        sampleTick = 1'b1;
        repeat (10) @(negedge clk_sys);
        check("limiterActive", 32'h1, {31'h0, limiterActive});
        check("freq reduced", 32'h1, {31'h0, freqCommand < 16'sh03E8});
        motion_drive_start_cmd = 1'b0;
        repeat (2) @(negedge clk_sys);
        check("freq passed", 32'h0000_03E8, {16'h0, freqCommand});
        ctrlMode = MODE_NOT_FREQ;
        motion_drive_start_cmd = 1'b1;
        @(negedge clk_sys);
        check("limiterActive", 32'h0, {31'h0, limiterActive});
        // light load: current stays under the ceiling, reference untouched
        ctrlMode = MODE_BASIC_VHZ;
        {loadAmps, velocityReference} = {16'h0000, 16'sh0190};
        repeat (20) @(negedge clk_sys);
        check("freq untouched", 32'h0000_0190, {16'h0, freqCommand});
        attr('{1'b1, ATTR_GUARD_ENABLE, 32'h0000_0000, 1'b0, 32'h0000_0001});
        ctrlMode = MODE_FAN_PUMP;
        for (int i = 0; i < 4; i++)
        begin
            velocityReference = fp[i][0];
            repeat (6) @(negedge clk_sys);
            check("fan/pump volt", {16'h0, fp[i][1]}, {16'h0, outputVoltage});
        end
        // sensorless at standstill: current equals the load
        ctrlMode = MODE_SENSORLESS;
        {velocityReference, loadAmps} = {16'sh0000, 16'h0200};
        repeat (5) @(negedge clk_sys);
        check("boost volt", 32'h0000_0164, {16'h0, outputVoltage});
        check("slip", 32'h0000_0010, {16'h0, slipEstimate});
        // reset in mid-run drops the enable again
        attr('{1'b1, ATTR_GUARD_ENABLE, 32'h0000_0001, 1'b0, 32'h0000_0000});
        rstn = 1'b0;
        repeat (2) @(negedge clk_sys);
        rstn = 1'b1;
        @(negedge clk_sys);
        check("limiterActive", 32'h0, {31'h0, limiterActive});
        attr('{1'b0, ATTR_GUARD_ENABLE, 32'h0000_0000, 1'b0, 32'h0000_0000});
        close_out();
    end
endmodule : testbench

`default_nettype wire
